// >>> logic/ssp_pkg.sv
package ssp_pkg;

	// ==========================================================
	// Mode codes
	localparam logic [3:0] MODE_M_DIV4  = 4'h0;
	localparam logic [3:0] MODE_M_DIV16 = 4'h1;
	localparam logic [3:0] MODE_M_DIV64 = 4'h2;
	localparam logic [3:0] MODE_M_TMR   = 4'h3;
	localparam logic [3:0] MODE_S_SEL   = 4'h4;
	localparam logic [3:0] MODE_S_NOSEL = 4'h5;

	// ==========================================================
	// Timing
	localparam int         CLK_PERIOD_NS  = 5;
	localparam logic [5:0] HALF_DIV4      = 6'h02;
	localparam logic [5:0] HALF_DIV16     = 6'h08;
	localparam logic [5:0] HALF_DIV64     = 6'h20;
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	localparam int         SS_RESET_NS    = 50;
	localparam logic [7:0] SS_RESET_CYC   =
		8'((SS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [3:0] port_mode_select;
		logic       serial_port_enable;
		logic       clock_idle_polarity;
		logic       clock_edge_select;
		logic       input_sample_phase;
		logic       sdo_dir_input;
		logic       sck_dir_input;
	} cfg_t;

	typedef struct packed {
		logic buffer_full_flag;
		logic serial_irq_flag;
		logic write_collision_flag;
		logic receive_overflow_flag;
	} flags_t;

	// ==========================================================
	// Mode decoding
	function automatic logic is_master(input logic [3:0] m);
		return m[3:2] == 2'h0;
	endfunction : is_master

	function automatic logic is_slave(input logic [3:0] m);
		return (m == MODE_S_SEL) || (m == MODE_S_NOSEL);
	endfunction : is_slave

	function automatic logic [5:0] half_period(input logic [3:0] m);
		case (m)
			MODE_M_DIV16: return HALF_DIV16;
			MODE_M_DIV64: return HALF_DIV64;
			default:      return HALF_DIV4;
		endcase
	endfunction : half_period

endpackage : ssp_pkg

// >>> logic/bit_sync.sv
`timescale 1ns/1ps

module bit_sync #(
	parameter int W = 3
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	always_comb begin
		s_nxt        = s_r;
		s_nxt.meta   = d;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.stable;

endmodule : bit_sync

// >>> logic/bit_rate_div.sv
`timescale 1ns/1ps

module bit_rate_div (
	input  wire logic       mclk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic       run,
	input  wire logic [3:0] mode,
	input  wire logic       timer_two_tick,
	output logic            half_tick
);

	typedef struct packed {
		logic [5:0] cnt;
		logic       tick;
	} div_state_t;

	div_state_t s_r;
	div_state_t s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.tick = 1'b0;
		if (!run) begin
			s_nxt.cnt = 6'h00;
		end else if (mode == ssp_pkg::MODE_M_TMR) begin
			s_nxt.tick = timer_two_tick;
		end else if (s_r.cnt == ssp_pkg::half_period(mode) - 6'h01) begin
			s_nxt.cnt  = 6'h00;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 6'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign half_tick = s_r.tick;

endmodule : bit_rate_div

// >>> logic/sync_serial_port_spi.sv
`timescale 1ns/1ps

module sync_serial_port_spi (
	input  wire logic           mclk,
	input  wire logic           reset_n,
	input  wire logic           clk_en,
	input  wire ssp_pkg::cfg_t  cfg,
	input  wire logic           timer_two_tick,
	input  wire logic           device_asleep,
	input  wire logic           buf_wr,
	input  wire logic [7:0]     buf_wr_data,
	input  wire logic           buf_rd,
	input  wire logic           write_collision_flag_clear,
	input  wire logic           ovf_clear,
	input  wire logic           irq_clear,
	input  wire logic           sck_in,
	input  wire logic           sdi_in,
	input  wire logic           ss_n_in,
	output logic                sck_out,
	output logic                sck_oe,
	output logic                sdo_out,
	output logic                sdo_oe,
	output logic [7:0]          buf_rd_data,
	output ssp_pkg::flags_t     flags,
	output logic                busy,
	output logic                wake_pulse
);

	typedef struct packed {
		logic [7:0]      shreg;
		logic [7:0]      buf_data;
		logic            out_bit;
		logic            sck_lvl;
		logic            sck_prev;
		logic [4:0]      edge_cnt;
		logic [3:0]      bit_cnt;
		logic            cap_pend;
		logic            m_active;
		logic [7:0]      ss_cnt;
		ssp_pkg::flags_t flags;
		logic            wake;
		logic            busy;
		logic            sck_oe;
		logic            sdo_oe;
	} spi_state_t;

	spi_state_t s_r;
	spi_state_t s_nxt;
	logic [2:0] pins_s;
	logic       sck_s;
	logic       sdi_s;
	logic       ss_n_s;
	logic       half_tick;
	logic       spi_on;
	logic       master;
	logic       slave;
	logic       slave_act;
	logic       tx_rise;
	logic       done_c;

	// ==========================================================
	// Pin synchronisers and bit clock
	bit_sync #(.W(3)) u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.d       ({sck_in, sdi_in, ss_n_in}),
		.q       (pins_s)
	);

	assign sck_s  = pins_s[2];
	assign sdi_s  = pins_s[1];
	assign ss_n_s = pins_s[0];

	bit_rate_div u_div (
		.mclk           (mclk),
		.reset_n        (reset_n),
		.clk_en         (clk_en),
		.run            (s_r.m_active),
		.mode           (cfg.port_mode_select),
		.timer_two_tick (timer_two_tick),
		.half_tick      (half_tick)
	);

	// ==========================================================
	// Mode decode
	// non-SPI codes off
	assign spi_on    = cfg.serial_port_enable && (ssp_pkg::is_master(cfg.port_mode_select)
		|| ssp_pkg::is_slave(cfg.port_mode_select));
	assign master    = spi_on && ssp_pkg::is_master(cfg.port_mode_select);
	assign slave     = spi_on && ssp_pkg::is_slave(cfg.port_mode_select);
	assign slave_act = slave && (cfg.port_mode_select == ssp_pkg::MODE_S_NOSEL || !ss_n_s);
	assign tx_rise   = cfg.clock_edge_select ^ cfg.clock_idle_polarity;

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt          = s_r;
		s_nxt.wake     = 1'b0;
		s_nxt.sck_prev = sck_s;
		done_c         = 1'b0;
		if (write_collision_flag_clear) begin
			s_nxt.flags.write_collision_flag = 1'b0;
		end
		if (ovf_clear) begin
			s_nxt.flags.receive_overflow_flag = 1'b0;
		end
		if (irq_clear) begin
			s_nxt.flags.serial_irq_flag = 1'b0;
		end
		if (buf_rd) begin
			s_nxt.flags.buffer_full_flag = 1'b0;
		end
		if (!spi_on) begin
			s_nxt.m_active = 1'b0;
			s_nxt.edge_cnt = 5'h00;
			s_nxt.bit_cnt  = 4'h0;
			s_nxt.cap_pend = 1'b0;
			s_nxt.ss_cnt   = 8'h00;
			s_nxt.sck_lvl  = cfg.clock_idle_polarity;
			if (buf_wr) begin
				s_nxt.shreg   = buf_wr_data;
				s_nxt.out_bit = buf_wr_data[7];
			end
		end else if (master) begin
			if (buf_wr && s_r.m_active) begin
				s_nxt.flags.write_collision_flag = 1'b1;
			end
			if (!s_r.m_active) begin
				s_nxt.sck_lvl = cfg.clock_idle_polarity;
				if (buf_wr || cfg.sck_dir_input) begin
					s_nxt.m_active = 1'b1;
					s_nxt.edge_cnt = 5'h00;
					s_nxt.bit_cnt  = 4'h0;
					s_nxt.cap_pend = 1'b0;
					if (buf_wr) begin
						s_nxt.shreg   = buf_wr_data;
						s_nxt.out_bit = buf_wr_data[7];
					end else begin
						s_nxt.out_bit = s_r.shreg[7];
					end
				end
			end else if (half_tick) begin
				if (s_r.cap_pend) begin
					s_nxt.shreg    = {s_r.shreg[6:0], sdi_s};
					s_nxt.bit_cnt  = s_r.bit_cnt + 4'h1;
					s_nxt.cap_pend = 1'b0;
				end
				if (s_r.edge_cnt != ssp_pkg::EDGES_PER_BYTE) begin
					s_nxt.sck_lvl  = ~s_r.sck_lvl;
					s_nxt.edge_cnt = s_r.edge_cnt + 5'h01;
					if (s_nxt.sck_lvl == tx_rise) begin
						s_nxt.out_bit = s_nxt.shreg[7];
					end else if (cfg.input_sample_phase) begin
						s_nxt.cap_pend = 1'b1;
					end else begin
						s_nxt.shreg   = {s_nxt.shreg[6:0], sdi_s};
						s_nxt.bit_cnt = s_nxt.bit_cnt + 4'h1;
					end
				end
				if (s_nxt.bit_cnt == ssp_pkg::BITS_PER_BYTE && !s_nxt.cap_pend
					&& s_nxt.edge_cnt == ssp_pkg::EDGES_PER_BYTE) begin
					done_c         = 1'b1;
					s_nxt.m_active = 1'b0;
					s_nxt.bit_cnt  = 4'h0;
				end
			end
		end else begin
			if (cfg.port_mode_select == ssp_pkg::MODE_S_SEL && ss_n_s) begin
				if (s_r.ss_cnt != ssp_pkg::SS_RESET_CYC) begin
					s_nxt.ss_cnt = s_r.ss_cnt + 8'h01;
				end
				if (s_r.ss_cnt == ssp_pkg::SS_RESET_CYC - 8'h01) begin
					s_nxt.bit_cnt = 4'h0;
					s_nxt.out_bit = s_r.shreg[7];
				end
			end else begin
				s_nxt.ss_cnt = 8'h00;
			end
			if (buf_wr) begin
				if (s_r.bit_cnt != 4'h0) begin
					s_nxt.flags.write_collision_flag = 1'b1;
				end else begin
					s_nxt.shreg   = buf_wr_data;
					s_nxt.out_bit = buf_wr_data[7];
				end
			end
			if (slave_act && sck_s != s_r.sck_prev) begin
				if (sck_s == tx_rise) begin
					s_nxt.out_bit = s_nxt.shreg[7];
				end else begin
					s_nxt.shreg   = {s_nxt.shreg[6:0], sdi_s};
					s_nxt.bit_cnt = s_nxt.bit_cnt + 4'h1;
					if (s_nxt.bit_cnt == ssp_pkg::BITS_PER_BYTE) begin
						done_c        = 1'b1;
						s_nxt.bit_cnt = 4'h0;
						s_nxt.out_bit = s_nxt.shreg[7];
					end
				end
			end
		end
		if (done_c) begin
			if (slave && s_nxt.flags.buffer_full_flag) begin
				s_nxt.flags.receive_overflow_flag = 1'b1;
			end else begin
				s_nxt.buf_data               = s_nxt.shreg;
				s_nxt.flags.buffer_full_flag = 1'b1;
				s_nxt.flags.serial_irq_flag  = 1'b1;
			end
			s_nxt.wake = slave && device_asleep;
		end
		s_nxt.busy   = s_nxt.m_active || (s_nxt.bit_cnt != 4'h0);
		s_nxt.sck_oe = master && !cfg.sck_dir_input;
		s_nxt.sdo_oe = spi_on && !cfg.sdo_dir_input && (master
			|| cfg.port_mode_select == ssp_pkg::MODE_S_NOSEL
			|| (cfg.port_mode_select == ssp_pkg::MODE_S_SEL && !ss_n_s));
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_r <= '0;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign sck_out     = s_r.sck_lvl;
	assign sck_oe      = s_r.sck_oe;
	assign sdo_out     = s_r.out_bit;
	assign sdo_oe      = s_r.sdo_oe;
	assign buf_rd_data = s_r.buf_data;
	assign flags       = s_r.flags;
	assign busy        = s_r.busy;
	assign wake_pulse  = s_r.wake;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	sequence s_master_start;
		clk_en && master && !s_r.m_active && buf_wr;
	endsequence

	sequence s_master_done;
		clk_en && master && done_c;
	endsequence

	a_master_write_start: assert property (
		s_master_start |=> s_r.m_active && sdo_out == $past(buf_wr_data[7]))
		else $error("master write did not start transfer");

	a_clock_rests_idle: assert property (
		s_master_done |=> sck_out == $past(cfg.clock_idle_polarity) && !s_r.m_active)
		else $error("clock not at idle level after byte");

	a_byte_sets_flags: assert property (
		s_master_done |=> flags.buffer_full_flag && flags.serial_irq_flag
			&& buf_rd_data == $past(s_nxt.shreg))
		else $error("completed byte did not load buffer and flags");

	a_busy_write_coll: assert property (
		clk_en && master && s_r.m_active && buf_wr && !half_tick
			|=> flags.write_collision_flag && $stable(s_r.shreg))
		else $error("busy write not flagged or not dropped");

	a_coll_stays_set: assert property (
		flags.write_collision_flag && !(clk_en && write_collision_flag_clear) |=> flags.write_collision_flag)
		else $error("collision flag dropped without clear");

	a_read_clears_full: assert property (
		clk_en && buf_rd && !done_c |=> !flags.buffer_full_flag)
		else $error("buffer read did not clear full flag");

	a_master_no_ovf: assert property (
		clk_en && master && !flags.receive_overflow_flag |=> !flags.receive_overflow_flag)
		else $error("overflow set in master mode");

	a_select_floats_out: assert property (
		clk_en && slave && cfg.port_mode_select == ssp_pkg::MODE_S_SEL && ss_n_s
			|=> !sdo_oe)
		else $error("data out driven with select high");

	a_off_is_quiet: assert property (
		clk_en && !spi_on |=> !sck_oe && !sdo_oe && !busy)
		else $error("SPI pins driven while not in SPI mode");

endmodule : sync_serial_port_spi

// >>> dv/spi_far_end.sv
`timescale 1ns/1ps

module spi_far_end (
	input  wire logic sck_out,
	input  wire logic sck_oe,
	input  wire logic sdo_out,
	input  wire logic sdo_oe,
	output logic      sck_in,
	output logic      sdi_in,
	output logic      ss_n_in
);
	logic [7:0] s_tx;
	logic [7:0] s_rx;

	initial begin
		sck_in = 1'b0;
		sdi_in = 1'b0;
		ss_n_in = 1'b1;
		s_tx = 8'h00;
		s_rx = 8'h00;
	end

	always @(posedge sck_out) begin
		if (sck_oe) begin
			sdi_in = s_tx[7];
			s_tx = {s_tx[6:0], ~s_tx[7]};
		end
	end

	always @(negedge sck_out) begin
		if (sck_oe) begin
			s_rx = {s_rx[6:0], sdo_oe ? sdo_out : ~sdo_out};
		end
	end

	task automatic xfer(input logic [7:0] tx, input int nbits, input int pause_at,
		output logic [7:0] rx, output logic oe_gap);
		// Whole-nanosecond steps keep pin changes off the block's rising clock edges.
		#0.5;
		rx = 8'h00;
		oe_gap = 1'b0;
		ss_n_in = 1'b0;
		#48;
		for (int i = 0; i < nbits; i++) begin
			if (i == pause_at) begin
				ss_n_in = 1'b1;
				#30;
				oe_gap = sdo_oe;
				ss_n_in = 1'b0;
				#48;
			end
			sck_in = 1'b1;
			sdi_in = tx[7 - i];
			#24;
			sck_in = 1'b0;
			rx = {rx[6:0], sdo_oe ? sdo_out : ~sdo_out};
			#24;
		end
		ss_n_in = 1'b1;
		sdi_in = ~sdi_in;
	endtask : xfer
endmodule : spi_far_end

// >>> dv/sync_serial_port_spi_tb.sv
`timescale 1ns/1ps

module sync_serial_port_spi_tb;
	logic            mclk;
	logic            reset_n;
	logic            clk_en;
	ssp_pkg::cfg_t   cfg;
	logic            timer_two_tick;
	logic            device_asleep;
	logic            buf_wr;
	logic [7:0]      buf_wr_data;
	logic            buf_rd;
	logic            write_collision_flag_clear;
	logic            ovf_clear;
	logic            irq_clear;
	logic            sck_in;
	logic            sdi_in;
	logic            ss_n_in;
	logic            sck_out;
	logic            sck_oe;
	logic            sdo_out;
	logic            sdo_oe;
	logic [7:0]      buf_rd_data;
	ssp_pkg::flags_t flags;
	logic            busy;
	logic            wake_pulse;
	logic            oe_seen;
	logic            wake_seen;
	logic [7:0]      rx;
	logic            gap;
	int              error_cnt;
	int              checked;

	sync_serial_port_spi dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .cfg(cfg),
		.timer_two_tick(timer_two_tick), .device_asleep(device_asleep), .buf_wr(buf_wr),
		.buf_wr_data(buf_wr_data), .buf_rd(buf_rd), .write_collision_flag_clear(write_collision_flag_clear),
		.ovf_clear(ovf_clear), .irq_clear(irq_clear), .sck_in(sck_in), .sdi_in(sdi_in),
		.ss_n_in(ss_n_in), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .buf_rd_data(buf_rd_data), .flags(flags), .busy(busy),
		.wake_pulse(wake_pulse));

	spi_far_end far (.sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .sck_in(sck_in), .sdi_in(sdi_in), .ss_n_in(ss_n_in));

	// ==========================================================
	// Clock, timer ticks and monitors
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		timer_two_tick = 1'b0;
		forever begin
			repeat (2) @(posedge mclk);
			#1 timer_two_tick = 1'b1;
			@(posedge mclk);
			#1 timer_two_tick = 1'b0;
		end
	end

	always @(posedge mclk) begin
		if (sdo_oe === 1'b1) oe_seen = 1'b1;
		if (wake_pulse === 1'b1) wake_seen = 1'b1;
	end

	// ==========================================================
	// Helpers
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h", $time, msg, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] b);
		buf_wr = 1'b1;
		buf_wr_data = b;
		step(1);
		buf_wr = 1'b0;
	endtask : wr

	task automatic clr_all;
		{buf_rd, write_collision_flag_clear, ovf_clear, irq_clear} = 4'hF;
		step(1);
		{buf_rd, write_collision_flag_clear, ovf_clear, irq_clear} = 4'h0;
		step(1);
	endtask : clr_all

	task automatic wait_idle;
		for (int i = 0; i < 3000 && busy !== 1'b0; i++) step(1);
		step(2);
		chk(busy, 1'b0, "transfer ended");
	endtask : wait_idle

	task automatic set_cfg(input logic [3:0] m, input logic p, input logic d);
		cfg.serial_port_enable = 1'b0;
		step(1);
		cfg = '{port_mode_select: m, serial_port_enable: 1'b0, clock_idle_polarity: p,
			clock_edge_select: (m != ssp_pkg::MODE_S_NOSEL), input_sample_phase: 1'b0,
			sdo_dir_input: d, sck_dir_input: m[2]};
		step(1);
		cfg.serial_port_enable = 1'b1;
		step(2);
	endtask : set_cfg

	task automatic set_opt(input logic [1:0] opt);
		cfg.serial_port_enable = 1'b0;
		step(1);
		{cfg.input_sample_phase, cfg.sck_dir_input} = opt;
		step(1);
		cfg.serial_port_enable = 1'b1;
		step(2);
	endtask : set_opt

	// ==========================================================
	// Scenarios
	task automatic t_master;
		set_cfg(ssp_pkg::MODE_M_DIV16, 1'b0, 1'b0);
		far.s_tx = 8'h3C;
		wr(8'hA5);
		chk(busy, 1'b1, "busy after write");
		step(1);
		wr(8'h11);
		clk_en = 1'b0;
		step(12);
		chk({sck_out, busy, flags}, 8'h12, "frozen by enable");
		clk_en = 1'b1;
		wait_idle;
		chk(far.s_rx, 8'hA5, "master sent");
		chk(buf_rd_data, 8'h3C, "master received");
		chk(flags, 4'hE, "master flags");
		chk(sck_out, 1'b0, "clock rests");
		clr_all;
		chk(flags, 4'h0, "flags cleared");
		$display("test master done");
	endtask : t_master

	task automatic t_rates;
		int n;
		int exp [4] = '{4, 16, 64, 6};
		for (int m = 0; m < 4; m++) begin
			set_cfg(4'(m), m[0], 1'b0);
			chk(sck_out, m[0], "idle level");
			wr(8'h00);
			n = 0;
			for (int i = 0; i < 100 && sck_out === m[0]; i++) step(1);
			while (n < 200 && sck_out !== m[0]) begin
				step(1);
				n++;
			end
			while (n < 200 && sck_out === m[0]) begin
				step(1);
				n++;
			end
			chk(8'(n), 8'(exp[m]), "bit period");
			wait_idle;
			clr_all;
		end
		$display("test rates done");
	endtask : t_rates

	task automatic t_late;
		set_cfg(ssp_pkg::MODE_M_DIV16, 1'b0, 1'b0);
		set_opt(2'h2);
		far.s_tx = 8'h96;
		wr(8'h3C);
		wait_idle;
		chk(far.s_rx, 8'h3C, "late phase sent");
		chk(buf_rd_data, 8'h96, "late phase received");
		clr_all;
		$display("test late sample done");
	endtask : t_late

	task automatic t_listen;
		set_cfg(ssp_pkg::MODE_M_DIV4, 1'b0, 1'b0);
		far.sdi_in = 1'b1;
		set_opt(2'h1);
		step(80);
		chk({sck_oe, flags}, 8'h0C, "line monitor flags");
		chk(buf_rd_data, 8'hFF, "line monitor byte");
		cfg.serial_port_enable = 1'b0;
		step(1);
		clr_all;
		$display("test listen done");
	endtask : t_listen

	task automatic t_slave;
		set_cfg(ssp_pkg::MODE_S_SEL, 1'b0, 1'b0);
		wr(8'h5A);
		device_asleep = 1'b1;
		wake_seen = 1'b0;
		far.xfer(8'hC3, 8, 3, rx, gap);
		step(6);
		chk(rx, 8'h5A, "slave sent");
		chk(gap, 1'b0, "released in pause");
		chk(buf_rd_data, 8'hC3, "slave received");
		chk(flags, 4'hC, "slave flags");
		chk(wake_seen, 1'b1, "wake");
		far.xfer(8'h96, 8, 99, rx, gap);
		step(6);
		chk(flags, 4'hD, "overflow flags");
		chk(buf_rd_data, 8'hC3, "buffer kept");
		clr_all;
		far.xfer(8'hFF, 3, 99, rx, gap);
		step(40);
		far.xfer(8'h81, 8, 99, rx, gap);
		step(6);
		chk(buf_rd_data, 8'h81, "byte realigned");
		device_asleep = 1'b0;
		clr_all;
		$display("test slave done");
	endtask : t_slave

	task automatic t_quiet;
		set_cfg(ssp_pkg::MODE_S_NOSEL, 1'b0, 1'b1);
		oe_seen = 1'b0;
		far.xfer(8'h55, 8, 99, rx, gap);
		step(6);
		chk(oe_seen, 1'b0, "data-out silent");
		chk(flags.buffer_full_flag, 1'b1, "byte without select");
		clr_all;
		set_cfg(4'h6, 1'b0, 1'b0);
		far.xfer(8'hAA, 8, 99, rx, gap);
		step(6);
		chk({oe_seen, flags}, 8'h00, "two-wire code idle");
		$display("test quiet done");
	endtask : t_quiet

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		cfg = '0;
		{device_asleep, buf_wr, buf_rd, write_collision_flag_clear, ovf_clear, irq_clear} = 6'h00;
		buf_wr_data = 8'h00;
		{oe_seen, wake_seen} = 2'h0;
		error_cnt = 0;
		checked = 0;
		step(10);
		reset_n = 1'b1;
		step(1);
		chk({sck_out, sck_oe, sdo_oe, busy, flags}, 8'h00, "reset state");
		t_master;
		t_rates;
		t_late;
		t_listen;
		t_slave;
		t_quiet;
		tally_and_finish;
	end

	initial begin
		#300000;
		error_cnt++;
		tally_and_finish;
	end
endmodule : sync_serial_port_spi_tb
